// *** inc/rx_slicer_pkg.sv ***
/*
 Shared constants, register map and carrier types of the receive gain
 compensation and slicer stage.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rx_slicer_pkg;
   localparam int NUM_RX = 4;
   localparam int IDX_W = 8;
   localparam int TABLE_DEPTH = 256;
   localparam int SAMPLE_W = 16;
   localparam int LINK_W = 24;
   localparam int POS_W = 4;
   localparam int MANT_W = 12;
   localparam int MANT_FRAC = 11;
   // Gains are held in half-decibel units
   localparam logic [6:0] MAX_COMP_HDB = 7'h64;
   localparam logic [4:0] HDB_PER_BIT = 5'h0c;
   localparam logic [3:0] MAX_GAIN_SHIFT = 4'h8;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MANUAL_IDX = 8'h04;
   localparam logic [7:0] OFS_PIN_OE = 8'h08;
   localparam logic [7:0] OFS_TABLE_ADDR = 8'h0c;
   localparam logic [7:0] OFS_TABLE_DATA = 8'h10;
   localparam logic [7:0] OFS_POS_STATUS = 8'h14;
   localparam logic [7:0] OFS_IDX_STATUS = 8'h18;

   // Control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_STEP_LSB = 2;
   localparam int CTRL_FMT_LSB = 5;
   localparam int CTRL_PARITY_BIT = 8;
   localparam int CTRL_WIDTH_LSB = 9;
   localparam int CTRL_MANUAL_BIT = 11;
   localparam logic [11:0] CTRL_RST = 12'h000;

   localparam logic [1:0] MODE_UNCOMP = 2'h0;
   localparam logic [1:0] MODE_PIN = 2'h1;
   localparam logic [1:0] MODE_EMBED = 2'h2;

   localparam logic [1:0] WIDTH_12 = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_24 = 2'h2;

   localparam logic [2:0] FMT_NONE = 3'h0;
   localparam logic [2:0] FMT_1_MSB = 3'h1;
   localparam logic [2:0] FMT_1_LSB = 3'h2;
   localparam logic [2:0] FMT_2_MSB_3B = 3'h3;
   localparam logic [2:0] FMT_2_MSB_4B = 3'h4;
   localparam logic [2:0] FMT_2_LSB_3B = 3'h5;
   localparam logic [2:0] FMT_2_LSB_4B = 3'h6;

   // Lowest pin of each receiver's position nibble
   localparam int PIN_LSB [NUM_RX] = '{8, 12, 4, 0};

   typedef struct packed {
      logic [7:0] atten;
      logic [6:0] gain_hdb;
      logic [3:0] shift;
      logic [MANT_W-1:0] mant;
   } table_entry_t;

   localparam table_entry_t ENTRY_RST = '{atten: 8'h00, gain_hdb: 7'h00, shift: 4'h0, mant: 12'h800};

   typedef struct packed {
      logic [1:0] rx;
      logic signed [SAMPLE_W-1:0] i;
      logic signed [SAMPLE_W-1:0] q;
   } sample_in_t;

   typedef struct packed {
      logic [1:0] rx;
      logic [POS_W-1:0] pos;
      logic [LINK_W-1:0] i;
      logic [LINK_W-1:0] q;
   } link_word_t;
endpackage

// *** verilog/rx_gain_comp_slicer.sv ***
/*
 Receive gain compensation, slicer and slicer position reporting for four
 receivers, with an APB register slave and a two-entry output buffer.
 Assumes the gain index inputs and the sample stream come from logic on pclk,
 and that the pad logic resolves the slicer pins from the output enables.
*/
// Local design decisions: register access over APB and the register offsets.
// Operation
// - In compensation modes, digital gain equals the front-end attenuation of the index.
// - Digital gain and attenuator setting both come from one gain table entry.
// - Total digital gain compensation is clamped to 50 dB.
// - Index comes from the automatic gain loop or the manual index register.
// - Uncompensated mode bypasses slicer; words leave as 12, 16 or 24 bits.
// - Uncompensated mode only applies the small table gain, no slicing.
// - Width grows one bit for every 6 dB of gain above 16 bits.
// - Slicer keeps the MSBs, dropping one LSB per bit of growth.
// - Pin mode drives the current position on the pins without link alignment.
// - Slicer step is 1, 2, 3, 4, 6 or 8 dB per position.
// - Each receiver reports a 4-bit position on its own pins.
// - Pins 11..8, 15..12, 7..4, 3..0 carry receivers one to four.
// - Position is 0 at zero gain, then one more per started step.
// - Embedded mode leaves the pins undriven and puts position in I and Q.
// - One or two bits per component, at MSB or LSB positions.
// - Two-bit formats carry 3 or 4 bits; the fourth is zero or parity.
`timescale 1ns/1ns
module rx_gain_comp_slicer
   import rx_slicer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_RX-1:0][IDX_W-1:0] agc_gain_index,
   input wire logic in_valid,
   output logic in_ready,
   input wire sample_in_t in_sample,
   output logic out_valid,
   input wire logic out_ready,
   output link_word_t out_word,
   output logic [NUM_RX-1:0][7:0] fe_atten,
   output logic [15:0] slicer_gpio_out,
   output logic [15:0] slicer_gpio_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Slicer step in half-decibel units
   function automatic logic [4:0] step_hdb(input logic [2:0] sel);
      logic [4:0] s;
      s = 5'h0c;
      case (sel)
         3'h0: s = 5'h02;
         3'h1: s = 5'h04;
         3'h2: s = 5'h06;
         3'h3: s = 5'h08;
         3'h4: s = 5'h0c;
         3'h5: s = 5'h10;
         default: s = 5'h0c;
      endcase
      return s;
   endfunction

   // Zero at zero gain, else one plus the number of whole steps reached, at most 15
   function automatic logic [3:0] step_count(input logic [6:0] hdb, input logic [4:0] step);
      logic [3:0] n;
      logic [10:0] thr;
      n = 4'h0;
      thr = 11'h000;
      if (hdb != 7'h00) begin
         for (int k = 0; k < 15; k++) begin
            thr = 11'(k) * {6'h00, step};
            if ({4'h0, hdb} >= thr) begin
               n = 4'(k + 1);
            end
         end
      end
      return n;
   endfunction

   // Digital gain, then slicer shift, then saturation to the 16-bit slice
   function automatic logic [SAMPLE_W-1:0] gain_slice(input logic signed [SAMPLE_W-1:0] s,
         input logic [MANT_W-1:0] mant, input logic [3:0] sh, input logic [3:0] drop);
      logic signed [28:0] prod;
      logic signed [33:0] wide;
      logic [SAMPLE_W-1:0] r;
      prod = s * $signed({1'b0, mant});
      wide = $signed(34'(prod)) >>> MANT_FRAC;
      wide = wide <<< sh;
      wide = wide >>> drop;
      if (wide > 34'sd32767) begin
         r = 16'h7fff;
      end else if (wide < -34'sd32768) begin
         r = 16'h8000;
      end else begin
         r = wide[SAMPLE_W-1:0];
      end
      return r;
   endfunction

   // Bit index of the lowest valid bit of a left-aligned word
   function automatic logic [4:0] word_lsb(input logic [1:0] wsel);
      logic [4:0] b;
      b = 5'h08;
      case (wsel)
         WIDTH_12: b = 5'h0c;
         WIDTH_24: b = 5'h00;
         default: b = 5'h08;
      endcase
      return b;
   endfunction

   // Slice is left-aligned in 24 bits; embedding then right-aligning to the selected link width
   function automatic logic [LINK_W-1:0] pack_word(input logic [SAMPLE_W-1:0] s, input logic [1:0] wsel,
         input logic en, input logic two, input logic at_msb, input logic [1:0] bits);
      logic [LINK_W-1:0] la;
      logic [4:0] lsb;
      la = {s, 8'h00};
      lsb = word_lsb(wsel);
      if (en) begin
         if (at_msb && two) begin
            la = {bits, la[LINK_W-1:2]};
         end else if (at_msb) begin
            la = {bits[0], la[LINK_W-1:1]};
         end else if (two) begin
            la[lsb +: 2] = bits;
         end else begin
            la[lsb] = bits[0];
         end
      end
      return la >> lsb;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [11:0] ctrl_q;
   logic [NUM_RX-1:0][IDX_W-1:0] manual_idx_q;
   logic [15:0] pin_oe_q;
   logic [IDX_W-1:0] table_addr_q;
   table_entry_t table_q [TABLE_DEPTH];
   logic [NUM_RX-1:0][POS_W-1:0] pos_q;
   logic [NUM_RX-1:0][3:0] drop_q;
   logic [NUM_RX-1:0][3:0] shift_q;
   logic [NUM_RX-1:0][MANT_W-1:0] mant_q;
   logic [NUM_RX-1:0][IDX_W-1:0] cur_idx_q;

   logic [1:0] mode;
   logic [2:0] step_sel;
   logic [2:0] fmt;
   logic parity_sel;
   logic [1:0] width_sel;
   logic manual_gain_mode;
   logic setup;
   logic wr;
   logic mapped;
   logic [31:0] rd_d;

   assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
   assign step_sel = ctrl_q[CTRL_STEP_LSB +: 3];
   assign fmt = ctrl_q[CTRL_FMT_LSB +: 3];
   assign parity_sel = ctrl_q[CTRL_PARITY_BIT];
   assign width_sel = ctrl_q[CTRL_WIDTH_LSB +: 2];
   assign manual_gain_mode = ctrl_q[CTRL_MANUAL_BIT];

   // Reads are decoded in the setup cycle so that the answer comes from flops;
   // writes land only at the edge that completes the access phase
   assign setup = psel && !penable;
   assign wr = psel && penable && pready && pwrite && mapped;

   always_comb begin
      mapped = 1'b1;
      rd_d = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: rd_d = {20'h00000, ctrl_q};
         OFS_MANUAL_IDX: rd_d = manual_idx_q;
         OFS_PIN_OE: rd_d = {16'h0000, pin_oe_q};
         OFS_TABLE_ADDR: rd_d = {24'h000000, table_addr_q};
         OFS_TABLE_DATA: rd_d = {1'b0, table_q[table_addr_q]};
         OFS_POS_STATUS: rd_d = {16'h0000, pos_q};
         OFS_IDX_STATUS: rd_d = cur_idx_q;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         manual_idx_q <= '0;
         pin_oe_q <= 16'h0000;
         table_addr_q <= 8'h00;
      end else if (ce && wr) begin
         case (paddr)
            OFS_CTRL: ctrl_q <= pwdata[11:0];
            OFS_MANUAL_IDX: manual_idx_q <= pwdata;
            OFS_PIN_OE: pin_oe_q <= pwdata[15:0];
            OFS_TABLE_ADDR: table_addr_q <= pwdata[IDX_W-1:0];
            default: ;
         endcase
      end
   end

   // Gain table; one entry pairs attenuator setting and digital gain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int e = 0; e < TABLE_DEPTH; e++) begin
            table_q[e] <= ENTRY_RST;
         end
      end else if (ce && wr && paddr == OFS_TABLE_DATA) begin
         table_q[table_addr_q] <= pwdata[30:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-receiver gain lookup and slicer position

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_idx_q <= '0;
         fe_atten <= '0;
         pos_q <= '0;
         drop_q <= '0;
         shift_q <= '0;
         mant_q <= '0;
      end else if (ce) begin
         for (int r = 0; r < NUM_RX; r++) begin
            logic [IDX_W-1:0] idx;
            table_entry_t ent;
            logic [6:0] hdb;
            logic comp;
            idx = manual_gain_mode ? manual_idx_q[r] : agc_gain_index[r];
            ent = table_q[idx];
            hdb = (ent.gain_hdb > MAX_COMP_HDB) ? MAX_COMP_HDB : ent.gain_hdb;
            comp = (mode == MODE_PIN) || (mode == MODE_EMBED);
            cur_idx_q[r] <= idx;
            fe_atten[r] <= ent.atten;
            mant_q[r] <= ent.mant;
            shift_q[r] <= (ent.shift > MAX_GAIN_SHIFT) ? MAX_GAIN_SHIFT : ent.shift;
            // Uncompensated mode never slices, so the table's small trims pass through
            drop_q[r] <= comp ? step_count(hdb, HDB_PER_BIT) : 4'h0;
            pos_q[r] <= comp ? step_count(hdb, step_hdb(step_sel)) : 4'h0;
         end
      end
   end

   // Pins follow the position directly; link latency is the far side's concern
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slicer_gpio_out <= 16'h0000;
         slicer_gpio_oe <= 16'h0000;
      end else if (ce) begin
         for (int r = 0; r < NUM_RX; r++) begin
            slicer_gpio_out[PIN_LSB[r] +: POS_W] <= (mode == MODE_PIN) ? pos_q[r] : 4'h0;
         end
         slicer_gpio_oe <= (mode == MODE_PIN) ? pin_oe_q : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sample path

   link_word_t new_word;
   logic push;

   always_comb begin
      logic [POS_W-1:0] pos;
      logic [3:0] s4;
      logic emb;
      logic two;
      logic at_msb;
      logic [SAMPLE_W-1:0] si;
      logic [SAMPLE_W-1:0] sq;
      logic [1:0] bi;
      logic [1:0] bq;
      // Position and gain of the same receiver are taken together with the sample
      pos = pos_q[in_sample.rx];
      si = gain_slice(in_sample.i, mant_q[in_sample.rx], shift_q[in_sample.rx], drop_q[in_sample.rx]);
      sq = gain_slice(in_sample.q, mant_q[in_sample.rx], shift_q[in_sample.rx], drop_q[in_sample.rx]);
      emb = (mode == MODE_EMBED) && (fmt != FMT_NONE) && (fmt <= FMT_2_LSB_4B);
      two = (fmt >= FMT_2_MSB_3B);
      at_msb = (fmt == FMT_1_MSB) || (fmt == FMT_2_MSB_3B) || (fmt == FMT_2_MSB_4B);
      s4 = pos;
      if (fmt == FMT_2_MSB_3B || fmt == FMT_2_LSB_3B) begin
         s4[3] = parity_sel ? ^pos[2:0] : 1'b0;
      end
      bi = two ? s4[3:2] : {1'b0, s4[1]};
      bq = two ? s4[1:0] : {1'b0, s4[0]};
      new_word.rx = in_sample.rx;
      new_word.pos = pos;
      new_word.i = pack_word(si, width_sel, emb, two, at_msb, bi);
      new_word.q = pack_word(sq, width_sel, emb, two, at_msb, bq);
   end

   assign push = in_valid && in_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry output buffer: head register plus one spare slot

   link_word_t spare_q;
   logic spare_valid_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_word <= '0;
         spare_q <= '0;
         spare_valid_q <= 1'b0;
         in_ready <= 1'b0;
      end else if (ce) begin
         if (out_ready || !out_valid) begin
            if (spare_valid_q) begin
               out_word <= spare_q;
               out_valid <= 1'b1;
               spare_valid_q <= push;
               if (push) begin
                  spare_q <= new_word;
               end
               in_ready <= !push;
            end else begin
               out_valid <= push;
               if (push) begin
                  out_word <= new_word;
               end
               in_ready <= 1'b1;
            end
         end else if (push) begin
            spare_q <= new_word;
            spare_valid_q <= 1'b1;
            in_ready <= 1'b0;
         end else begin
            in_ready <= !spare_valid_q;
         end
      end
   end

endmodule

// *** tb/rx_slicer_asserts.sv ***
/*
 Port checker for the slicer stage: bus answers, output buffer, settled pins.
 Assumes it is bound into the stage, with one clock pclk.
*/
`timescale 1ns/1ns
module rx_slicer_asserts
   import rx_slicer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_RX-1:0][IDX_W-1:0] agc_gain_index,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire link_word_t out_word,
   input wire logic [NUM_RX-1:0][7:0] fe_atten,
   input wire logic [15:0] slicer_gpio_out,
   input wire logic [15:0] slicer_gpio_oe
);
   logic [1:0] occ_q;
   logic [2:0] quiet_q;
   logic [NUM_RX-1:0][IDX_W-1:0] idx_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   // Buffer fill seen from the two handshakes alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         occ_q <= 2'h0;
      end else if (ce) begin
         occ_q <= occ_q + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
      end
   end
   // Edges since the last index change, bus access or low clock enable; pins lag two edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_q <= 3'h0;
         idx_q <= '0;
      end else begin
         idx_q <= agc_gain_index;
         if (psel || !ce || agc_gain_index != idx_q) begin
            quiet_q <= 3'h0;
         end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence setup_s;
      psel && !penable && ce;
   endsequence
   sequence stalled_s;
      out_valid && !out_ready;
   endsequence
   apb_answer_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_in_access_a: assert property (pslverr |-> pready)
      else $error("error outside access");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   no_take_full_a: assert property (in_ready |-> occ_q != 2'h2)
      else $error("ready while buffer full");
   valid_tracks_a: assert property (out_valid == (occ_q != 2'h0))
      else $error("valid does not match fill");
   hold_stall_a: assert property (stalled_s |=> out_valid && $stable(out_word))
      else $error("word changed while stalled");
   refill_a: assert property (!in_ready && out_valid && out_ready |-> ##[1:2] in_ready)
      else $error("no ready after pop");
   frozen_a: assert property (!ce |=> $stable(fe_atten) && $stable(out_valid) && $stable(in_ready) && $stable(pready))
      else $error("state moved with clock enable low");
   pins_settled_a: assert property (quiet_q >= 3'h4 |-> $stable(slicer_gpio_out) && $stable(slicer_gpio_oe)
      && $stable(fe_atten))
      else $error("pins moved without cause");
endmodule

// *** tb/bb_sink.sv ***
/*
 Baseband side model: accepts link words with random stalls.
 Assumes the bench seeds the random generator before reset ends.
*/
`timescale 1ns/1ns
module bb_sink
   import rx_slicer_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic out_valid,
   input wire link_word_t out_word,
   input wire logic [6:0] stall_pct,
   output logic out_ready,
   output logic got,
   output link_word_t got_word
);
   // Ready is drawn every cycle, so stalls of any length occur
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ready <= 1'b0;
         got <= 1'b0;
         got_word <= '0;
      end else begin
         out_ready <= ($urandom % 100) >= stall_pct;
         got <= out_valid && out_ready;
         got_word <= out_word;
      end
   end
endmodule

// *** tb/tb_top.sv ***
/*
 Self-checking bench for the slicer stage over all modes and steps and the six embedding formats.
 Assumes the package, the stage and bb_sink are compiled first.
*/
`timescale 1ns/1ns
module tb_top
   import rx_slicer_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0, ce = 1;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, ix, oe;
   logic pready, pslverr, in_ready, out_valid, out_ready, got, man;
   logic [NUM_RX-1:0][IDX_W-1:0] agc_gain_index = '0;
   sample_in_t in_sample = '0;
   link_word_t out_word, got_word, expq[$];
   logic [NUM_RX-1:0][7:0] fe_atten;
   logic [15:0] slicer_gpio_out, slicer_gpio_oe, pins;
   logic [6:0] stall_pct = 0;
   logic [1:0] mode;
   int err_count, n_compared, stepc, fmt, par, wdt, sel[4];
   int g_hdb[4] = '{0, 5, 36, 127};
   int g_sh[4] = '{0, 1, 3, 8};
   int stp[6] = '{2, 4, 6, 8, 12, 16};
   always #20 pclk = ~pclk;
   rx_gain_comp_slicer rx_gain_comp_slicer_i (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .agc_gain_index, .in_valid, .in_ready, .in_sample, .out_valid,
      .out_ready, .out_word, .fe_atten, .slicer_gpio_out, .slicer_gpio_oe);
   bb_sink bb_sink_i (.pclk, .presetn, .out_valid, .out_word, .stall_pct, .out_ready, .got, .got_word);
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(logic [63:0] seen, logic [63:0] want);
      n_compared++;
      if (seen !== want) begin
         err_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic give_up(int n, int lim);
      if (n >= lim) begin
         err_count++;
         end_of_test();
      end
   endtask
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      give_up(n, 20);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      // One idle edge so that the next call never reassigns psel in this time step
      @(posedge pclk);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1, a, d, rd, er);
   endtask
   task automatic rdchk(logic [7:0] a, logic [31:0] want, logic want_er);
      logic [31:0] rd;
      logic er;
      apb(0, a, 0, rd, er);
      check(rd, want);
      check(er, want_er);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] posx(int e);
      int h;
      h = g_hdb[e] > 100 ? 100 : g_hdb[e];
      if (mode == MODE_UNCOMP || h == 0) return 4'h0;
      return 4'(h / stp[stepc] + 1 > 15 ? 15 : h / stp[stepc] + 1);
   endfunction
   function automatic logic [15:0] sat16(int v);
      return 16'(v > 32767 ? 32767 : (v < -32768 ? -32768 : v));
   endfunction
   // Left-align in 24 bits, embed, then right-align to the selected link width
   function automatic logic [23:0] emb(logic [15:0] d, logic [1:0] v);
      logic [23:0] la;
      int lsb;
      lsb = wdt == 0 ? 12 : (wdt == 2 ? 0 : 8);
      la = {d, 8'h00};
      case (mode == MODE_EMBED ? fmt : 0)
         1: la = {v[0], la[23:1]};
         2: la[lsb] = v[0];
         3, 4: la = {v, la[23:2]};
         5, 6: la[lsb +: 2] = v;
         default: ;
      endcase
      return la >> lsb;
   endfunction
   function automatic link_word_t exp_word(logic [1:0] rx, int xi, int xq);
      link_word_t w;
      int e, d;
      logic [3:0] p, b;
      e = sel[rx];
      p = posx(e);
      d = p == 0 ? 0 : (g_hdb[e] > 100 ? 100 : g_hdb[e]) / 12 + 1;
      b = (fmt == 3 || fmt == 5) ? {(par != 0) & ^p[2:0], p[2:0]} : p;
      w = '0;
      w.rx = rx;
      w.pos = p;
      w.i = emb(sat16((xi <<< g_sh[e]) >>> d), fmt < 3 ? {1'b0, p[1]} : b[3:2]);
      w.q = emb(sat16((xq <<< g_sh[e]) >>> d), fmt < 3 ? {1'b0, p[0]} : b[1:0]);
      return w;
   endfunction
   // Input is held high across back-to-back sends; the caller lowers it
   task automatic send(logic [1:0] rx, int xi, int xq);
      int n;
      in_valid <= 1;
      in_sample <= '{rx: rx, i: xi[15:0], q: xq[15:0]};
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (in_ready !== 1'b1 && n < 300);
      give_up(n, 300);
      expq.push_back(exp_word(rx, xi, xq));
   endtask
   task automatic drain;
      int n;
      in_valid <= 0;
      n = 0;
      while (expq.size() != 0 && n < 500) begin
         @(posedge pclk);
         n++;
      end
      give_up(n, 500);
   endtask
   always @(posedge pclk) begin
      if (got) begin
         check(got_word, expq.size() != 0 ? expq.pop_front() : '1);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(38));
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rdchk(OFS_CTRL, {20'h0, CTRL_RST}, 0);
      rdchk(8'h1c, 32'h0, 1);
      for (int e = 0; e < 4; e++) begin
         wr(OFS_TABLE_ADDR, 32'h40 + 32'(e));
         wr(OFS_TABLE_DATA, {1'b0, 8'h20 + 8'(e), 7'(g_hdb[e]), 4'(g_sh[e]), 12'h800});
      end
      for (int r = 0; r < 18; r++) begin
         mode = 2'(r % 3);
         stepc = (r / 3) % 6;
         fmt = stepc + 1;
         wdt = (r / 6) % 3;
         par = $urandom % 2;
         man = r >= 9;
         oe = $urandom;
         for (int k = 0; k < 4; k++) begin
            sel[k] = $urandom % 4;
            ix[k * 8 +: 8] = 8'h40 + 8'(sel[k]);
         end
         agc_gain_index <= man ? $urandom : ix;
         wr(OFS_PIN_OE, {16'h0, oe[15:0]});
         wr(OFS_MANUAL_IDX, man ? ix : $urandom);
         wr(OFS_CTRL, {20'h0, man, 2'(wdt), 1'(par), 3'(fmt), 3'(stepc), mode});
         repeat (4) @(posedge pclk);
         pins = '0;
         for (int k = 0; k < 4; k++) begin
            check(fe_atten[k], 8'h20 + 8'(sel[k]));
            pins[PIN_LSB[k] +: 4] = posx(sel[k]);
            ix[k * 4 +: 4] = posx(sel[k]);
         end
         check(slicer_gpio_out, mode == MODE_PIN ? pins : 16'h0);
         check(slicer_gpio_oe, mode == MODE_PIN ? oe[15:0] : 16'h0);
         rdchk(OFS_POS_STATUS, {16'h0, ix[15:0]}, 0);
         if (r == 0) begin
            // Index moves while the clock enable is low: attenuator setting must hold
            ce <= 0;
            agc_gain_index <= ~agc_gain_index;
            repeat (3) @(posedge pclk);
            check(fe_atten[0], 8'h20 + 8'(sel[0]));
            ce <= 1;
            agc_gain_index <= ~agc_gain_index;
            repeat (3) @(posedge pclk);
            stall_pct <= 100;
            send(0, 1, -1);
            send(1, 2, -2);
            in_valid <= 0;
            repeat (2) @(posedge pclk);
            check(in_ready, 1'b0);
            stall_pct <= 0;
            drain();
         end
         stall_pct <= 7'(r % 2 ? 60 : 0);
         send(2'($urandom), 32767, -32768);
         for (int s = 0; s < 6; s++) begin
            send(2'($urandom), int'($urandom % 32768) - 16384, int'($urandom % 32768) - 16384);
         end
         drain();
      end
      end_of_test();
   end
endmodule
bind rx_gain_comp_slicer rx_slicer_asserts rx_slicer_asserts_i (.pclk, .presetn, .ce, .psel, .penable, .prdata,
   .pready, .pslverr, .agc_gain_index, .in_valid, .in_ready, .out_valid, .out_ready, .out_word, .fe_atten,
   .slicer_gpio_out, .slicer_gpio_oe);
